/* fsq_pkg.sv */
// shared constants and types of the fault restart and wake sequencer
package fsq_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int TICK_US = 500;
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US;
  localparam int FAULT_WAIT_MS = 100;
  localparam int WAKE_PULSE_MS = 25;
  localparam int RECOVER_MS = 32;
  localparam logic [8:0] FAULT_WAIT_TICKS = 9'(FAULT_WAIT_MS * 1000 / TICK_US);
  localparam logic [8:0] WAKE_PULSE_TICKS = 9'(WAKE_PULSE_MS * 1000 / TICK_US);
  localparam logic [8:0] RECOVER_TICKS = 9'(RECOVER_MS * 1000 / TICK_US);
  // 1 ms in ticks, shifted by the reset delay select
  localparam logic [8:0] RST_DLY_BASE_TICKS = 9'(1000 / TICK_US);
  localparam int ST_ACTIVE = 0;
  localparam int ST_LOW_POWER = 1;
  localparam int ST_HIBERNATE = 2;
  localparam logic [1:0] STEP_FIRST = 2'h1;
  localparam logic [1:0] STEP_LAST = 2'h3;
  localparam logic [5:0] VCODE_MAX = 6'h32;
  localparam logic [2:0] RST_DLY_SEL_RESET = 3'h4;
  localparam logic [2:0] STEP_DLY_SEL_RESET = 3'h1;
  localparam logic [1:0] SSR_SEL_RESET = 2'h0;

  typedef enum logic [2:0] {
    FSQ_OFF = 3'b000,
    FSQ_STEP_DLY = 3'b001,
    FSQ_RAMP = 3'b010,
    FSQ_RST_DLY = 3'b011,
    FSQ_ACTIVE = 3'b100,
    FSQ_LOW_POWER = 3'b101,
    FSQ_HIBERNATE = 3'b110,
    FSQ_FAULT_WAIT = 3'b111
  } fsq_state_t;

  typedef struct packed {
    logic [2:0][2:0] en_by_state;
    logic [2:0][2:0] pfm_by_state;
    logic [2:0][1:0] ssr_sel;
    logic [2:0][1:0] step_assign;
    logic [2:0][2:0] dly_sel;
    logic [2:0][5:0] vcode;
    logic [2:0] short_retry;
    logic [2:0] discharge;
    logic [2:0] phase180;
    logic hyst1;
    logic [2:0] rst_dly_sel;
    logic awk_dis;
  } fsq_cfg_t;
endpackage

/* fsq_tmr_if.sv */
// tick and millisecond timer signals shared by the sequencer's modules
`timescale 1ns/1ps
interface fsq_tmr_if;
  logic tick;
  logic start;
  logic [8:0] load;
  logic [8:0] elapsed;
  logic expired;
  modport div (output tick, input start);
  modport tmr (input tick, input start, input load, output elapsed, output expired);
  modport ctl (output start, output load, input elapsed, input expired);
endinterface

/* fsq_tick_div.sv */
// divider that makes the half-millisecond tick enable
`timescale 1ns/1ps
module fsq_tick_div
  import fsq_pkg::*;
#(
  parameter logic [15:0] TICK_CYCLES = 16'(TICK_CYC)
) (
  input wire logic core_clk,
  input wire logic resetn,
  fsq_tmr_if.div t
);
  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } fsq_div_t;
  fsq_div_t q;
  fsq_div_t d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    // restarting with the timer keeps the first tick a full period away
    if (t.start || q.cnt == TICK_CYCLES - 16'h0001) begin
      d.cnt = 16'h0000;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
    d.tick = !t.start && q.cnt == TICK_CYCLES - 16'h0001;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign t.tick = q.tick;
endmodule

/* fsq_ms_timer.sv */
// restartable tick counter for every sequence delay
`timescale 1ns/1ps
module fsq_ms_timer
  import fsq_pkg::*;
(
  input wire logic core_clk,
  input wire logic resetn,
  fsq_tmr_if.tmr t
);
  typedef struct packed {
    logic [8:0] cnt;
    logic [8:0] load;
  } fsq_tmr_t;
  fsq_tmr_t q;
  fsq_tmr_t d;

  always_comb begin
    d = q;
    if (t.start) begin
      d.cnt = 9'h000;
      d.load = t.load;
    end else if (t.tick && q.cnt != 9'h1ff) begin
      d.cnt = q.cnt + 9'h001;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign t.elapsed = q.cnt;
  assign t.expired = q.cnt >= q.load;
endmodule

/* fsq_sequencer.sv */
// power sequencer: start-up steps, power states, fault restart and wake pulse
`timescale 1ns/1ps
module fsq_sequencer
  import fsq_pkg::*;
#(
  parameter logic [15:0] TICK_CYCLES = 16'(TICK_CYC)
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start_request_in_n,
  input wire logic power_hold_in,
  input wire logic low_power_request_in,
  input wire logic fault_in,
  input wire logic [2:0] rail_power_good,
  input wire logic [2:0] rail_short,
  input wire logic [2:0][2:0] otp_enable_by_state,
  input wire logic [2:0][2:0] otp_pfm_by_state,
  input wire logic [2:0][1:0] soft_start_rate_sel,
  input wire logic [2:0][1:0] sequence_step_assign,
  input wire logic [2:0][2:0] turn_on_delay_sel,
  input wire logic [2:0][5:0] rail_voltage_code,
  input wire logic [2:0] short_retry_protect_enable,
  input wire logic [2:0] output_discharge_enable,
  input wire logic [2:0] phase_shift_enable,
  input wire logic rail1_hysteretic_enable,
  input wire logic [2:0] reset_release_delay_sel,
  input wire logic auto_wake_pulse_disable,
  output logic start_echo_out_n,
  output logic system_reset_out_n,
  output logic auto_wake_pulse,
  output logic [2:0] rail_enable,
  output logic [2:0] rail_pfm,
  output logic [2:0] rail_discharge,
  output logic [2:0] rail_phase180,
  output logic [2:0][1:0] rail_ssr_sel,
  output logic [2:0][5:0] rail_vcode,
  output logic rail1_hysteretic,
  output logic [2:0] seq_state
);
  typedef struct packed {
    fsq_state_t st;
    logic [1:0] step;
    logic [2:0] on;
    logic hib_fault;
    logic restarting;
    logic hold_prev;
    logic cfg_ok;
    fsq_cfg_t cfg;
    logic rst_n;
    logic echo_n;
    logic awk;
    logic [2:0] pulse_frequency_mode;
    logic [2:0] dis;
    logic hyst;
  } fsq_seq_t;

  fsq_seq_t q;
  fsq_seq_t d;
  fsq_tmr_if tif();
  logic go;
  logic [8:0] ld;
  logic valid;
  logic trip;
  logic [2:0] mask;

  fsq_tick_div #(.TICK_CYCLES(TICK_CYCLES)) u_div (
    .core_clk(core_clk),
    .resetn(resetn),
    .t(tif.div)
  );

  fsq_ms_timer u_tmr (
    .core_clk(core_clk),
    .resetn(resetn),
    .t(tif.tmr)
  );

  assign tif.start = go;
  assign tif.load = ld;

  // turn-on delay select to ticks: 0, 0.5, 1, 2, 4, 8, 12, 16 ms
  function automatic logic [8:0] dly_ticks(input logic [2:0] sel);
    case (sel)
      3'h0: dly_ticks = 9'h000;
      3'h6: dly_ticks = 9'h018;
      3'h7: dly_ticks = 9'h020;
      default: dly_ticks = 9'h001 << (sel - 3'h1);
    endcase
  endfunction

  function automatic logic [2:0] step_mask(input fsq_cfg_t c, input logic [1:0] s);
    for (int i = 0; i < 3; i++) begin
      step_mask[i] = c.step_assign[i] == s;
    end
  endfunction

  // several rails on one step wait for the longest of their delays
  function automatic logic [8:0] step_delay(input fsq_cfg_t c, input logic [1:0] s);
    step_delay = 9'h000;
    for (int i = 0; i < 3; i++) begin
      if (c.step_assign[i] == s && dly_ticks(c.dly_sel[i]) > step_delay) begin
        step_delay = dly_ticks(c.dly_sel[i]);
      end
    end
  endfunction

  always_comb begin
    d = q;
    go = 1'b0;
    ld = 9'h000;
    valid = !start_request_in_n || power_hold_in || q.restarting;
    mask = step_mask(q.cfg, q.step);
    trip = |(rail_short & ~q.cfg.short_retry & q.on) || fault_in;
    d.hold_prev = power_hold_in;
    if (!q.cfg_ok) begin
      d.cfg_ok = 1'b1;
      d.cfg.en_by_state = otp_enable_by_state;
      d.cfg.pfm_by_state = otp_pfm_by_state;
      d.cfg.ssr_sel = soft_start_rate_sel;
      d.cfg.step_assign = sequence_step_assign;
      d.cfg.dly_sel = turn_on_delay_sel;
      d.cfg.short_retry = short_retry_protect_enable;
      d.cfg.discharge = output_discharge_enable;
      d.cfg.phase180 = phase_shift_enable;
      d.cfg.hyst1 = rail1_hysteretic_enable;
      d.cfg.rst_dly_sel = reset_release_delay_sel;
      d.cfg.awk_dis = auto_wake_pulse_disable;
      for (int i = 0; i < 3; i++) begin
        d.cfg.vcode[i] = rail_voltage_code[i] > VCODE_MAX ? VCODE_MAX : rail_voltage_code[i];
      end
    end
    case (q.st)
      FSQ_OFF: begin
        d.rst_n = 1'b0;
        d.on = 3'h0;
        if (q.cfg_ok && valid) begin
          d.step = STEP_FIRST;
          go = 1'b1;
          ld = step_delay(q.cfg, STEP_FIRST);
          d.st = FSQ_STEP_DLY;
        end
      end
      FSQ_STEP_DLY: begin
        if (tif.expired) begin
          if (q.step == STEP_FIRST && !valid) begin
            d.st = FSQ_OFF;
          end else if ((mask & ~q.on) != 3'h0) begin
            d.on = q.on | mask;
            go = 1'b1;
            ld = RECOVER_TICKS;
            d.st = FSQ_RAMP;
          end else if (q.step == STEP_LAST) begin
            go = 1'b1;
            ld = RST_DLY_BASE_TICKS << q.cfg.rst_dly_sel;
            d.st = FSQ_RST_DLY;
          end else begin
            d.step = q.step + 2'h1;
            go = 1'b1;
            ld = step_delay(q.cfg, q.step + 2'h1);
          end
        end
      end
      FSQ_RAMP: begin
        if ((rail_power_good & q.on) == q.on) begin
          go = 1'b1;
          if (q.step == STEP_LAST) begin
            ld = RST_DLY_BASE_TICKS << q.cfg.rst_dly_sel;
            d.st = FSQ_RST_DLY;
          end else begin
            d.step = q.step + 2'h1;
            ld = step_delay(q.cfg, q.step + 2'h1);
            d.st = FSQ_STEP_DLY;
          end
        end else if (tif.expired) begin
          d.st = FSQ_OFF;
          d.on = 3'h0;
          d.restarting = 1'b0;
        end
      end
      FSQ_RST_DLY: begin
        if (tif.expired) begin
          if ((rail_power_good & q.on) != q.on) begin
            d.st = FSQ_OFF;
            d.on = 3'h0;
            d.restarting = 1'b0;
          end else if (power_hold_in) begin
            d.rst_n = 1'b1;
            d.restarting = 1'b0;
            d.st = low_power_request_in ? FSQ_LOW_POWER : FSQ_ACTIVE;
          end
        end
      end
      FSQ_ACTIVE, FSQ_LOW_POWER: begin
        if (!power_hold_in) begin
          d.rst_n = 1'b0;
          d.st = low_power_request_in ? FSQ_HIBERNATE : FSQ_OFF;
        end else begin
          d.st = low_power_request_in ? FSQ_LOW_POWER : FSQ_ACTIVE;
        end
      end
      FSQ_HIBERNATE: begin
        if (!low_power_request_in) begin
          d.st = FSQ_OFF;
        end else if (power_hold_in && !q.hold_prev) begin
          // rails kept on through hibernate are skipped by the steps
          d.step = STEP_FIRST;
          go = 1'b1;
          ld = step_delay(q.cfg, STEP_FIRST);
          d.st = FSQ_STEP_DLY;
        end
      end
      FSQ_FAULT_WAIT: begin
        d.on = 3'h0;
        if (tif.expired) begin
          d.restarting = 1'b1;
          d.hib_fault = 1'b0;
          d.step = STEP_FIRST;
          go = 1'b1;
          ld = step_delay(q.cfg, STEP_FIRST);
          d.st = FSQ_STEP_DLY;
        end
      end
      default: begin
        d.st = FSQ_OFF;
      end
    endcase
    case (d.st)
      FSQ_ACTIVE: d.on = q.cfg.en_by_state[ST_ACTIVE];
      FSQ_LOW_POWER: d.on = q.cfg.en_by_state[ST_LOW_POWER];
      FSQ_HIBERNATE: d.on = q.cfg.en_by_state[ST_HIBERNATE];
      FSQ_OFF: d.on = 3'h0;
      default: d.on = d.on;
    endcase
    // fault shuts all rails and waits
    if (trip && q.st != FSQ_OFF && q.st != FSQ_FAULT_WAIT) begin
      d.st = FSQ_FAULT_WAIT;
      d.on = 3'h0;
      d.rst_n = 1'b0;
      d.hib_fault = q.st == FSQ_HIBERNATE;
      go = 1'b1;
      ld = FAULT_WAIT_TICKS;
    end
    case (d.st)
      FSQ_LOW_POWER: d.pulse_frequency_mode = q.cfg.pfm_by_state[ST_LOW_POWER];
      FSQ_HIBERNATE: d.pulse_frequency_mode = q.cfg.pfm_by_state[ST_HIBERNATE];
      default: d.pulse_frequency_mode = q.cfg.pfm_by_state[ST_ACTIVE];
    endcase
    d.dis = ~d.on & q.cfg.discharge;
    d.hyst = q.cfg.hyst1 & d.pulse_frequency_mode[0];
    d.awk = q.st == FSQ_FAULT_WAIT && !go && q.hib_fault && !q.cfg.awk_dis
      && tif.elapsed < WAKE_PULSE_TICKS;
    d.echo_n = d.awk ? 1'b0 : start_request_in_n;
  end

  // all sequencer state in one register; the tick divider and timer keep their own
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
      q.st <= FSQ_OFF;
      q.echo_n <= 1'b1;
      q.cfg.rst_dly_sel <= RST_DLY_SEL_RESET;
      q.cfg.dly_sel <= {3{STEP_DLY_SEL_RESET}};
      q.cfg.ssr_sel <= {3{SSR_SEL_RESET}};
      q.cfg.discharge <= 3'h7;
    end else begin
      q <= d;
    end
  end

  assign start_echo_out_n = q.echo_n;
  assign system_reset_out_n = q.rst_n;
  assign auto_wake_pulse = q.awk;
  assign rail_enable = q.on;
  assign rail_pfm = q.pulse_frequency_mode;
  assign rail_discharge = q.dis;
  assign rail_phase180 = q.cfg.phase180;
  assign rail_ssr_sel = q.cfg.ssr_sel;
  assign rail_vcode = q.cfg.vcode;
  assign rail1_hysteretic = q.hyst;
  assign seq_state = q.st;
endmodule

/* fsq_seq_checker.sv */
// port assertions for the fault restart and wake sequencer
`timescale 1ns/1ps
module fsq_seq_checker
  import fsq_pkg::*;
#(
  parameter logic [15:0] TICK_CYCLES = 16'(TICK_CYC)
) (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start_request_in_n,
  input wire logic power_hold_in,
  input wire logic fault_in,
  input wire logic auto_wake_pulse_disable,
  input wire logic start_echo_out_n,
  input wire logic system_reset_out_n,
  input wire logic auto_wake_pulse,
  input wire logic [2:0] rail_enable,
  input wire logic [2:0] rail_discharge,
  input wire logic [2:0] seq_state
);
  localparam int WAIT_CYC = int'(FAULT_WAIT_TICKS) * int'(TICK_CYCLES);
  localparam int PULSE_CYC = int'(WAKE_PULSE_TICKS) * int'(TICK_CYCLES);
  int wait_q;
  int pulse_q;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // lengths of the current fault wait and wake pulse, in clocks
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wait_q <= 0;
      pulse_q <= 0;
    end else begin
      wait_q <= (seq_state == FSQ_FAULT_WAIT) ? wait_q + 1 : 0;
      pulse_q <= auto_wake_pulse ? pulse_q + 1 : 0;
    end
  end
  chk_echo_follows: assert property (
    !auto_wake_pulse && !$past(auto_wake_pulse)
    |-> start_echo_out_n == $past(start_request_in_n)) else $error("echo not following");
  chk_pulse_echo_low: assert property (
    auto_wake_pulse |-> !start_echo_out_n && seq_state == FSQ_FAULT_WAIT)
    else $error("pulse outside wait or echo high");
  chk_pulse_from_hib: assert property (
    $rose(auto_wake_pulse) |-> $past(seq_state, 2) == FSQ_HIBERNATE && !auto_wake_pulse_disable)
    else $error("pulse without hibernate fault");
  chk_pulse_length: assert property (
    $fell(auto_wake_pulse) |-> pulse_q >= PULSE_CYC - 3 && pulse_q <= PULSE_CYC + 3)
    else $error("wake pulse length wrong");
  chk_fault_enter: assert property (
    fault_in && seq_state inside {FSQ_ACTIVE, FSQ_LOW_POWER, FSQ_HIBERNATE}
    |-> ##[1:2] seq_state == FSQ_FAULT_WAIT) else $error("fault not taken");
  chk_wait_rails_off: assert property (
    seq_state == FSQ_FAULT_WAIT |-> rail_enable == 3'h0 && !system_reset_out_n)
    else $error("rails on during fault wait");
  chk_wait_full: assert property (
    $fell(seq_state == FSQ_FAULT_WAIT) |-> wait_q >= WAIT_CYC - 3 && wait_q <= WAIT_CYC + 3)
    else $error("fault wait length wrong");
  chk_release_hold: assert property (
    $rose(system_reset_out_n) |-> $past(power_hold_in)) else $error("reset released without hold");
  chk_hold_low_rst: assert property (
    !power_hold_in && seq_state inside {FSQ_ACTIVE, FSQ_LOW_POWER} |=> !system_reset_out_n)
    else $error("reset not asserted on hold low");
  chk_no_dis_on: assert property (
    (rail_discharge & rail_enable) == 3'h0) else $error("discharge on a live rail");
endmodule

bind fsq_sequencer fsq_seq_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .start_request_in_n(start_request_in_n),
  .power_hold_in(power_hold_in), .fault_in(fault_in),
  .auto_wake_pulse_disable(auto_wake_pulse_disable), .start_echo_out_n(start_echo_out_n),
  .system_reset_out_n(system_reset_out_n), .auto_wake_pulse(auto_wake_pulse),
  .rail_enable(rail_enable), .rail_discharge(rail_discharge), .seq_state(seq_state)
);

/* fsq_host_model.sv */
// host wake controller model: powers up when it sees the start echo low
`timescale 1ns/1ps
module fsq_host_model (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start_echo_out_n,
  input wire logic sleep_req,
  output logic power_hold_in
);
  logic [1:0] sync_q;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync_q <= 2'h3;
      power_hold_in <= 1'b0;
    end else begin
      sync_q <= {sync_q[0], start_echo_out_n};
      if (!sync_q[1]) begin
        power_hold_in <= 1'b1;
      end else if (sleep_req) begin
        power_hold_in <= 1'b0;
      end
    end
  end
endmodule

/* fault_restart_wake_sequencer_bench.sv */
// self-checking bench of the fault restart and wake sequencer
`timescale 1ns/1ps
module fault_restart_wake_sequencer_bench;
  import fsq_pkg::*;
  localparam int T = 10;
  logic core_clk, resetn, start_request_in_n, power_hold_in, low_power_request_in, fault_in;
  logic sleep_req, rail1_hysteretic_enable, auto_wake_pulse_disable;
  logic start_echo_out_n, system_reset_out_n, auto_wake_pulse, rail1_hysteretic;
  logic [2:0] rail_power_good, rail_short, short_retry_protect_enable, output_discharge_enable;
  logic [2:0] phase_shift_enable, reset_release_delay_sel, rail_enable, rail_pfm;
  logic [2:0] rail_discharge, rail_phase180, seq_state;
  logic [2:0] pg_block;
  logic [2:0][2:0] otp_enable_by_state, otp_pfm_by_state, turn_on_delay_sel;
  logic [2:0][1:0] soft_start_rate_sel, sequence_step_assign, rail_ssr_sel;
  logic [2:0][5:0] rail_voltage_code, rail_vcode;
  int errors = 0;
  int check_count = 0;
  int n, p, e, k;
  // rails report good as soon as they are enabled, unless blocked
  assign rail_power_good = rail_enable & ~pg_block;
  fsq_sequencer #(.TICK_CYCLES(16'(T))) u_dut (
    .core_clk, .resetn, .start_request_in_n, .power_hold_in, .low_power_request_in, .fault_in,
    .rail_power_good, .rail_short, .otp_enable_by_state, .otp_pfm_by_state, .soft_start_rate_sel,
    .sequence_step_assign, .turn_on_delay_sel, .rail_voltage_code, .short_retry_protect_enable,
    .output_discharge_enable, .phase_shift_enable, .rail1_hysteretic_enable,
    .reset_release_delay_sel, .auto_wake_pulse_disable, .start_echo_out_n, .system_reset_out_n,
    .auto_wake_pulse, .rail_enable, .rail_pfm, .rail_discharge, .rail_phase180, .rail_ssr_sel,
    .rail_vcode, .rail1_hysteretic, .seq_state
  );
  fsq_host_model u_host (.core_clk, .resetn, .start_echo_out_n, .sleep_req, .power_hold_in);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_state(input logic [2:0] s);
    // step off the edge so a state launched there is settled
    #1;
    n = 0;
    while (seq_state !== s && n < 9000) begin
      tick(1);
      n++;
    end
    check("state", seq_state, s);
  endtask
  // counts wait, pulse and echo-low cycles of one fault wait
  task automatic watch_wait();
    wait_state(FSQ_FAULT_WAIT);
    n = 0;
    p = 0;
    e = 0;
    while (seq_state === FSQ_FAULT_WAIT && n < 9000) begin
      p += int'(auto_wake_pulse === 1'b1);
      e += int'(start_echo_out_n === 1'b0);
      tick(1);
      n++;
    end
    k = int'(FAULT_WAIT_TICKS) * T;
    check("wait length", n >= k - 3 && n <= k + 3, 1);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  initial begin
    #(100 * 40000);
    errors++;
    end_of_test();
  end
  initial begin
    {resetn, start_request_in_n, low_power_request_in, fault_in, sleep_req} = 5'b01000;
    {rail_short, auto_wake_pulse_disable, reset_release_delay_sel} = 7'h01;
    pg_block = 3'h0;
    otp_enable_by_state = {3'b010, 3'b111, 3'b111};
    otp_pfm_by_state = {3'b111, 3'b011, 3'b000};
    soft_start_rate_sel = {2'h3, 2'h1, 2'h0};
    sequence_step_assign = {2'h3, 2'h2, 2'h1};
    turn_on_delay_sel = {3'h1, 3'h2, 3'h1};
    rail_voltage_code = {6'h3f, 6'h14, 6'h0a};
    short_retry_protect_enable = 3'b001;
    output_discharge_enable = 3'b101;
    phase_shift_enable = 3'b101;
    rail1_hysteretic_enable = 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      resetn <= 1'b0;
      // a mid-run reset must not carry the low power request over
      low_power_request_in <= 1'b0;
      pg_block <= 3'h0;
      auto_wake_pulse_disable <= i[0];
      reset_release_delay_sel <= i[0] ? 3'h0 : 3'h1;
      tick(1);
      check("reset echo", start_echo_out_n, 1);
      check("reset out", system_reset_out_n, 0);
      @(posedge core_clk);
      resetn <= 1'b1;
      tick(2);
      @(posedge core_clk);
      start_request_in_n <= 1'b0;
      tick(3);
      check("echo", start_echo_out_n, 0);
      wait_state(FSQ_RST_DLY);
      wait_state(FSQ_ACTIVE);
      k = (2 << reset_release_delay_sel) * T;
      check("reset delay", n >= k - 2 && n <= k + 3, 1);
      check("reset out", system_reset_out_n, 1);
      check("active rails", rail_enable, otp_enable_by_state[0]);
      check("active mode", rail_pfm, otp_pfm_by_state[0]);
      check("soft start", rail_ssr_sel, soft_start_rate_sel);
      check("vcode", rail_vcode, {6'h32, 6'h14, 6'h0a});
      check("phase", rail_phase180, phase_shift_enable);
      @(posedge core_clk);
      start_request_in_n <= 1'b1;
      low_power_request_in <= 1'b1;
      rail_short <= 3'b001;
      tick(3);
      check("short ignored", seq_state, FSQ_LOW_POWER);
      check("lp mode", rail_pfm, otp_pfm_by_state[1]);
      check("hysteretic", rail1_hysteretic, 1);
      @(posedge core_clk);
      rail_short <= 3'b000;
      sleep_req <= 1'b1;
      wait_state(FSQ_HIBERNATE);
      @(posedge core_clk);
      sleep_req <= 1'b0;
      tick(1);
      check("hib reset", system_reset_out_n, 0);
      check("hib rails", rail_enable, otp_enable_by_state[2]);
      check("hib discharge", rail_discharge, 3'b101);
      @(posedge core_clk);
      rail_short <= 3'b010;
      @(posedge core_clk);
      rail_short <= 3'b000;
      tick(2);
      check("fault rails", rail_enable, 0);
      watch_wait();
      k = i ? 0 : int'(WAKE_PULSE_TICKS) * T;
      check("pulse length", p >= k - 2 && p <= k + 2, 1);
      check("echo low", e, p);
      if (i == 1) begin
        wait_state(FSQ_RST_DLY);
        tick(400);
        check("stalled", {seq_state, system_reset_out_n}, {FSQ_RST_DLY, 1'b0});
        @(posedge core_clk);
        start_request_in_n <= 1'b0;
        repeat (5) @(posedge core_clk);
        start_request_in_n <= 1'b1;
      end
      wait_state(FSQ_LOW_POWER);
      @(posedge core_clk);
      fault_in <= 1'b1;
      @(posedge core_clk);
      fault_in <= 1'b0;
      watch_wait();
      check("no pulse", p, 0);
      wait_state(FSQ_LOW_POWER);
      // a rail that never reports good must abort the restart
      @(posedge core_clk);
      fault_in <= 1'b1;
      pg_block <= 3'b100;
      @(posedge core_clk);
      fault_in <= 1'b0;
      watch_wait();
      n = 0;
      while (rail_enable !== 3'b111 && n < 9000) begin
        tick(1);
        n++;
      end
      wait_state(FSQ_OFF);
      k = int'(RECOVER_TICKS) * T;
      check("recovery abort", n >= k - 2 && n <= k + 3, 1);
      check("abort rails", rail_enable, 0);
      $display("test %0d done", i);
    end
    end_of_test();
  end
endmodule
